// ===== shared/mrf_bank_if.sv
// Port between the slave core and its result word memory.
// Assumes writer and memory share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface mrf_bank_if #(parameter int WIDTH = 15, parameter int DEPTH = 8);
  localparam int AW = $clog2(DEPTH);
  logic wr_en;
  logic [AW-1:0] wr_idx;
  logic [WIDTH-1:0] wr_data;
  logic [AW-1:0] rd_idx;
  logic [WIDTH-1:0] rd_data;
  modport writer (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// ===== shared/mrf_pkg.sv
// Constants and types shared by the monitor result formatter and its bus slave.
// Assumes a single core clock domain; bus pins are sampled, not used as clocks.
// What this block does
// - Control bit 7 selects Celsius or Kelvin
// - Temperature LSB weighs one sixteenth degree
// - Temperature upper bit 7 is fresh flag
// - Upper bit 6 flags shorted remote sensor
// - Upper bit 5 flags open remote sensor
// - Sensor alarms meaningful only while fresh set
// - Upper holds bits 12..8, lower 7..0
// - Voltage upper bit 7 is fresh flag
// - Voltage bit 6 sign, bits 13..0 below
// - Single-ended LSB about 305.18 microvolts, positive
// - Differential LSB about 19.42 microvolts, signed
// - Supply equals 2.5 V plus code times LSB
// - Answer SMBus byte and word reads, writes
// - Slave only; clock input, data two-way
// - Work at 100 and 400 kbit/s
// - No result updates while a read runs
// - Lines are only pulled low, never driven
// - Start is data falling while clock high
// - Repeated start behaves exactly like start
// - Stop is data rising while clock high
// - Command byte loads low four pointer bits
// - Pointer advances per read byte, wraps zero
// - Both bytes of a result match
`default_nettype none
package mrf_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_TRIGGER = 4'h2;
  localparam logic [3:0] ADDR_FIRST_RESULT = 4'h4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int CTRL_KELVIN_BIT = 7;
  localparam logic [12:0] KELVIN_OFFSET = 13'h1112;
  localparam logic [2:0] SUPPLY_SLOT = 3'h5;
  localparam int NUM_RESULTS = 6;
  localparam int BANK_DEPTH = 8;
  localparam int WORD_WIDTH = 15;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SPIKE_NS = 50;
  localparam int FILTER_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_cmd, st_wdata, st_rdata, st_skip
  } mrf_state_type;
endpackage
`default_nettype wire

// ===== tb/mrf_bus_master.sv
// Two-wire bus master model for the monitor's slave port.
// Assumes pull-ups on both lines; a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module mrf_bus_master (
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_o
);
  // Only releases or pulls low; the clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Works from idle and, as a repeated start, from a low clock
  task automatic start();
    #40 sda_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
  endtask

  task automatic stop();
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask

  // Data changes mid-low, sampled mid-high; 160 ns per bit
  task automatic bit_cycle(input logic b, output logic s);
    #40 sda_o = b;
    #40 scl_o = 1'b1;
    #40 s = sda_line;
    #40 scl_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // Last byte of a read is refused so the slave lets go at once
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(~ack, s);
  endtask
endmodule
`default_nettype wire

// ===== tb/mrf_top_tb.sv
// Self-checking bench for the result formatter and its two-wire slave.
// Assumes the bus master model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mrf_top_tb;
  localparam logic [6:0] ADDR = 7'h4c;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic res_valid = 1'b0;
  logic [2:0] res_slot = 3'h0;
  logic res_is_temp = 1'b0;
  logic [13:0] res_code = 14'h0000;
  logic res_short = 1'b0;
  logic res_open = 1'b0;
  logic sda_out, sda_oe_n, res_ready, trigger, scl_o, sda_o, a;
  logic [7:0] control;
  logic [7:0] rx [0:3];
  logic [12:0] c;
  int failures = 0;
  int num_checks = 0;
  int trig_cnt = 0;
  wire logic sda_line = sda_o & (sda_oe_n | sda_out);

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (trigger === 1'b1) trig_cnt++;

  mrf_top #(.DEV_ADDR(ADDR), .FILTER_CYCLES(2)) dut_u (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .scl_in(scl_o), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .res_valid(res_valid), .res_slot(res_slot),
    .res_is_temp(res_is_temp), .res_code(res_code), .res_short(res_short),
    .res_open(res_open), .res_ready(res_ready), .control(control), .trigger(trigger));
  mrf_bus_master master_u (.sda_line(sda_line), .scl_o(scl_o), .sda_o(sda_o));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic addr_cmd(input logic [7:0] cmd);
    master_u.start();
    master_u.send({ADDR, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    master_u.send(cmd, a);
    chk({7'h00, a}, 8'h01);
  endtask

  task automatic rd_open();
    master_u.start();
    master_u.send({ADDR, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] cmd, input int nr);
    addr_cmd(cmd);
    rd_open();
    for (int i = 0; i < nr; i++) begin
      master_u.recv(i < nr - 1, rx[i]);
    end
    master_u.stop();
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input int nw);
    addr_cmd(cmd);
    master_u.send(d0, a);
    chk({7'h00, a}, 8'h01);
    if (nw > 1) begin
      master_u.send(8'h5a, a);
      chk({7'h00, a}, 8'h01);
    end
    master_u.stop();
  endtask

  // Waits for res_ready, then offers one result for a single clock cycle
  task automatic store(input logic [2:0] s, input logic t, input logic [13:0] d,
                       input logic sh, input logic op);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    while (res_ready !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({7'h00, res_ready}, 8'h01);
    res_slot = s;
    res_is_temp = t;
    res_code = d;
    res_short = sh;
    res_open = op;
    res_valid = 1'b1;
    @(posedge core_clk);
    #1;
    res_valid = 1'b0;
  endtask

  task automatic t_reset();
    chk(control, 8'h00);
    chk({6'h00, sda_oe_n, res_ready}, 8'h03);
    chk({7'h00, trigger}, 8'h00);
    chk({7'h00, sda_out}, 8'h00);
    $display("reset test done");
  endtask

  // Write word: control then trigger; upper command bits are ignored
  task automatic t_control();
    wr(8'h71, 8'h80, 2);
    chk(control, 8'h80);
    chk(trig_cnt[7:0], 8'h01);
    rd(8'h31, 1);
    chk(rx[0], 8'h80);
    $display("control test done");
  endtask

  task automatic t_temp();
    store(3'h0, 1'b1, 14'h12a0, 1'b1, 1'b0);
    rd(8'h04, 2);
    chk(rx[0], 8'hd2);
    chk(rx[1], 8'ha0);
    rd(8'h04, 1);
    chk(rx[0], 8'h52);
    wr(8'h01, 8'h00, 1);
    store(3'h0, 1'b1, 14'h1000, 1'b0, 1'b1);
    c = 13'h1000 - mrf_pkg::KELVIN_OFFSET;
    rd(8'h04, 2);
    chk(rx[0], {3'b101, c[12:8]});
    chk(rx[1], c[7:0]);
    $display("temperature test done");
  endtask

  // Negative differential code, supply code, then wrap into status
  task automatic t_volt();
    store(3'h1, 1'b0, 14'h2abc, 1'b0, 1'b0);
    store(3'h2, 1'b0, 14'h0001, 1'b0, 1'b0);
    store(3'h5, 1'b0, 14'h0123, 1'b0, 1'b0);
    rd(8'h06, 2);
    chk(rx[0], 8'hea);
    chk(rx[1], 8'hbc);
    rd(8'h0e, 3);
    chk(rx[0], 8'h81);
    chk(rx[1], 8'h23);
    chk(rx[2], 8'h04);
    $display("voltage test done");
  endtask

  // A result offered during a read waits until the read ends
  task automatic t_pause();
    addr_cmd(8'h06);
    rd_open();
    fork
      store(3'h1, 1'b0, 14'h0555, 1'b0, 1'b0);
      begin
        master_u.recv(1'b1, rx[0]);
        chk({7'h00, res_ready}, 8'h00);
        master_u.recv(1'b0, rx[1]);
        master_u.stop();
      end
    join
    chk(rx[0], 8'h6a);
    chk(rx[1], 8'hbc);
    rd(8'h06, 2);
    chk(rx[0], 8'h85);
    chk(rx[1], 8'h55);
    $display("pause test done");
  endtask

  task automatic t_bad_addr();
    master_u.start();
    master_u.send({ADDR ^ 7'h01, 1'b0}, a);
    master_u.stop();
    chk({7'h00, a}, 8'h00);
    $display("address test done");
  endtask

  // A result offered while the clock enable is low is not taken
  task automatic t_freeze();
    clk_en = 1'b0;
    store(3'h3, 1'b0, 14'h1234, 1'b0, 1'b0);
    clk_en = 1'b1;
    rd(8'h0a, 1);
    chk(rx[0], 8'h00);
    $display("clock enable test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    wrap_up();
  end

  initial begin
    #13 resetn = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    t_reset();
    t_control();
    t_temp();
    t_volt();
    t_pause();
    t_bad_addr();
    t_freeze();
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== verilog/mrf_pin_filter.sv
// Two-flop synchroniser and stability filter for each bus pin.
// Assumes pins idle high; output changes only after STABLE steady cycles.
`timescale 1ns/1ps
`default_nettype none
module mrf_pin_filter #(parameter int WIDTH = 2, parameter int STABLE = 4) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  localparam int CW = $clog2(STABLE + 1);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic meta;
      logic sync;
      logic level;
      logic [CW-1:0] cnt;
      // One flop per bit so no two processes write the output vector
      assign pin_out[g] = level;
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          meta <= 1'b1;
          sync <= 1'b1;
          cnt <= '0;
          level <= 1'b1;
        end else if (clk_en) begin
          meta <= pin_in[g];
          sync <= meta;
          if (sync == level) begin
            cnt <= '0;
          end else if (cnt == CW'(STABLE - 1)) begin
            level <= sync;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verilog/mrf_result_bank.sv
// Result word memory: one word holds both bytes of a result.
// Assumes one write port and one registered read port on core_clk.
`timescale 1ns/1ps
`default_nettype none
module mrf_result_bank #(parameter int WIDTH = 15, parameter int DEPTH = 8) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  mrf_bank_if.bank bus
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      bus.rd_data <= '0;
    end else if (clk_en) begin
      if (bus.wr_en) begin
        mem[bus.wr_idx] <= bus.wr_data;
      end
      bus.rd_data <= mem[bus.rd_idx];
    end
  end
endmodule
`default_nettype wire

// ===== verilog/mrf_top.sv
// Result formatter and two-wire slave of the voltage, current and temperature monitor.
// Assumes the sequencer offers one result at a time and waits while res_ready is low.
`timescale 1ns/1ps
`default_nettype none
module mrf_top #(
  parameter logic [6:0] DEV_ADDR = 7'h4c,
  parameter int FILTER_CYCLES = mrf_pkg::FILTER_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic res_valid,
  input wire logic [2:0] res_slot,
  input wire logic res_is_temp,
  input wire logic [13:0] res_code,
  input wire logic res_short,
  input wire logic res_open,
  output logic res_ready,
  output logic [7:0] control,
  output logic trigger
);
  localparam int NR = mrf_pkg::NUM_RESULTS;

  // Result slot for a result register address
  function automatic logic [2:0] mrf_slot(input logic [3:0] addr);
    mrf_slot = addr[3:1] - 3'h2;
  endfunction

  logic [1:0] filt;
  logic scl_q;
  logic sda_q;
  mrf_pkg::mrf_state_type state;
  mrf_pkg::mrf_state_type next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txreg;
  logic [7:0] next_txreg;
  logic [3:0] ptr;
  logic [3:0] next_ptr;
  logic rw;
  logic next_rw;
  logic reading;
  logic next_reading;
  logic next_oe_n;
  logic [NR-1:0] fresh;
  logic [NR-1:0] next_fresh;
  logic [7:0] tx_byte;
  logic reg_we;
  logic tx_load;
  logic cmd_done;

  mrf_bank_if #(.WIDTH(mrf_pkg::WORD_WIDTH), .DEPTH(mrf_pkg::BANK_DEPTH)) bank_bus ();

  mrf_pin_filter #(.WIDTH(2), .STABLE(FILTER_CYCLES)) u_filter (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in({scl_in, sda_in}),
    .pin_out(filt)
  );

  mrf_result_bank #(.WIDTH(mrf_pkg::WORD_WIDTH), .DEPTH(mrf_pkg::BANK_DEPTH)) u_bank (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .bus(bank_bus)
  );

  // Bus events from the filtered pins
  wire scl_rise = filt[1] & ~scl_q;
  wire scl_fall = ~filt[1] & scl_q;
  wire start = scl_q & filt[1] & sda_q & ~filt[0];
  wire stop = scl_q & filt[1] & ~sda_q & filt[0];
  wire busy = state != mrf_pkg::st_idle;
  wire addr_hit = shreg[7:1] == DEV_ADDR;
  wire [3:0] cmd_ptr = shreg[3:0];
  wire [3:0] ptr_inc = ptr + 4'h1;

  // Result formatting
  wire store = clk_en & res_valid & res_ready & (res_slot < 3'(NR));
  wire temp_fmt = res_is_temp & (res_slot != mrf_pkg::SUPPLY_SLOT);
  wire kelvin = control[mrf_pkg::CTRL_KELVIN_BIT];
  wire [12:0] temp_code = kelvin ? res_code[12:0]
                                 : res_code[12:0] - mrf_pkg::KELVIN_OFFSET;
  // Alarms are stored with their own result so fresh qualifies them
  wire [14:0] temp_word = {res_short, res_open, temp_code};
  // Voltage, current and supply codes pass as signed 14-bit codes
  wire [14:0] volt_word = {res_code[13], res_code};
  wire [14:0] fmt_word = temp_fmt ? temp_word : volt_word;

  assign bank_bus.wr_en = store;
  assign bank_bus.wr_idx = res_slot;
  assign bank_bus.wr_data = fmt_word;
  assign bank_bus.rd_idx = mrf_slot(ptr);

  // Fresh flags: a store wins over a clear in the same cycle
  wire [2:0] rd_slot = mrf_slot(ptr);
  wire is_result = ptr >= mrf_pkg::ADDR_FIRST_RESULT;
  wire [NR-1:0] set_mask = store ? NR'(1) << res_slot : '0;
  wire [NR-1:0] clr_mask = (clk_en & tx_load & is_result) ? NR'(1) << rd_slot : '0;
  assign next_fresh = (fresh & ~clr_mask) | set_mask;
  wire [7:0] status = {2'h0, fresh};

  // Byte offered to the master for the current pointer
  always_comb begin
    if (is_result && ptr[0]) begin
      tx_byte = bank_bus.rd_data[7:0];
    end else if (is_result) begin
      tx_byte = {fresh[rd_slot], bank_bus.rd_data[14:8]};
    end else if (ptr == mrf_pkg::ADDR_CONTROL) begin
      tx_byte = control;
    end else if (ptr == mrf_pkg::ADDR_STATUS || ptr == mrf_pkg::ADDR_TRIGGER) begin
      tx_byte = status;
    end else begin
      tx_byte = 8'h00;
    end
  end

  // Slave sequencer
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_txreg = txreg;
    next_ptr = ptr;
    next_rw = rw;
    next_reading = reading;
    next_oe_n = sda_oe_n;
    reg_we = 1'b0;
    tx_load = 1'b0;
    cmd_done = 1'b0;
    if (stop) begin
      next_state = mrf_pkg::st_idle;
      next_oe_n = 1'b1;
      next_reading = 1'b0;
    end else if (start) begin
      next_state = mrf_pkg::st_addr;
      next_bitcnt = 4'h0;
      next_oe_n = 1'b1;
      next_reading = 1'b0;
    end else if (busy && scl_rise) begin
      if (bitcnt < 4'h8) begin
        next_shreg = {shreg[6:0], filt[0]};
        next_bitcnt = bitcnt + 4'h1;
      end else begin
        next_bitcnt = 4'h9;
        // Master not acknowledging ends the read
        if (state == mrf_pkg::st_rdata && filt[0]) begin
          next_state = mrf_pkg::st_skip;
        end
      end
    end else if (busy && scl_fall) begin
      if (bitcnt == 4'h8) begin
        case (state)
          mrf_pkg::st_addr: begin
            if (addr_hit) begin
              next_oe_n = 1'b0;
              next_rw = shreg[0];
              next_reading = shreg[0];
            end else begin
              next_state = mrf_pkg::st_skip;
            end
          end
          mrf_pkg::st_cmd: begin
            next_oe_n = 1'b0;
            next_ptr = cmd_ptr;
            cmd_done = 1'b1;
          end
          mrf_pkg::st_wdata: begin
            next_oe_n = 1'b0;
            next_ptr = ptr_inc;
            reg_we = 1'b1;
          end
          default: begin
            next_oe_n = 1'b1;
          end
        endcase
      end else if (bitcnt == 4'h9) begin
        next_bitcnt = 4'h0;
        next_oe_n = 1'b1;
        case (state)
          mrf_pkg::st_addr: begin
            next_state = rw ? mrf_pkg::st_rdata : mrf_pkg::st_cmd;
          end
          mrf_pkg::st_cmd: begin
            next_state = mrf_pkg::st_wdata;
          end
          default: begin
            next_state = state;
          end
        endcase
        if (next_state == mrf_pkg::st_rdata) begin
          next_oe_n = tx_byte[7];
          next_txreg = {tx_byte[6:0], 1'b0};
          next_ptr = ptr_inc;
          tx_load = 1'b1;
        end
      end else if (state == mrf_pkg::st_rdata) begin
        next_oe_n = txreg[7];
        next_txreg = {txreg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= mrf_pkg::st_idle;
      bitcnt <= 4'h0;
    end else if (clk_en) begin
      scl_q <= filt[1];
      sda_q <= filt[0];
      state <= next_state;
      bitcnt <= next_bitcnt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 4'h0;
      rw <= 1'b0;
    end else if (clk_en) begin
      shreg <= next_shreg;
      txreg <= next_txreg;
      ptr <= next_ptr;
      rw <= next_rw;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reading <= 1'b0;
      res_ready <= 1'b1;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (clk_en) begin
      reading <= next_reading;
      res_ready <= ~next_reading;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fresh <= '0;
      control <= mrf_pkg::CONTROL_RESET;
      trigger <= 1'b0;
    end else if (clk_en) begin
      fresh <= next_fresh;
      if (reg_we && ptr == mrf_pkg::ADDR_CONTROL) begin
        control <= shreg;
      end
      trigger <= reg_we && ptr == mrf_pkg::ADDR_TRIGGER;
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ready_pause_a: assert property (reading |-> !res_ready && !store)
    else $error("result stored during a read");
  fresh_set_a: assert property (store |=> fresh[$past(res_slot)])
    else $error("fresh flag not set by a store");
  fresh_clear_a: assert property (
    clk_en && tx_load && is_result && !store |=> !fresh[$past(rd_slot)])
    else $error("fresh flag not cleared by a read");
  celsius_fmt_a: assert property (
    store && temp_fmt && !kelvin |-> 13'(fmt_word[12:0] + mrf_pkg::KELVIN_OFFSET)
      == res_code[12:0])
    else $error("Celsius code offset wrong");
  start_det_a: assert property (clk_en && start && !stop |=>
    state == mrf_pkg::st_addr && bitcnt == 4'h0)
    else $error("start not taken");
  stop_det_a: assert property (clk_en && stop |=>
    state == mrf_pkg::st_idle && sda_oe_n && res_ready)
    else $error("stop not taken");
  ptr_load_a: assert property (clk_en && cmd_done |=> ptr == $past(cmd_ptr))
    else $error("pointer not loaded from command");
  ptr_adv_a: assert property (clk_en && tx_load |=> ptr == $past(ptr_inc))
    else $error("pointer not advanced after read byte");
  sda_low_a: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  cmd_ack_a: assert property (
    clk_en && scl_fall && !start && !stop && bitcnt == 4'h8
      && state == mrf_pkg::st_cmd |=> !sda_oe_n ##0 bitcnt == 4'h8)
    else $error("command byte not acknowledged");
  alarm_keep_a: assert property (
    store && temp_fmt |-> fmt_word[14] == res_short && fmt_word[13] == res_open)
    else $error("sensor alarms not stored with result");

  // Register writes, formats and bus front end
  trig_pulse_a: assert property (
    clk_en && reg_we && ptr == mrf_pkg::ADDR_TRIGGER |=> trigger)
    else $error("trigger pulse missing after write");
  trig_once_a: assert property (trigger |=> !trigger)
    else $error("trigger pulse longer than one cycle");
  ctrl_load_a: assert property (
    clk_en && reg_we && ptr == mrf_pkg::ADDR_CONTROL |=> control == $past(shreg))
    else $error("control register not written");
  kelvin_fmt_a: assert property (
    store && temp_fmt && kelvin |-> fmt_word[12:0] == res_code[12:0])
    else $error("Kelvin code altered");
  volt_sign_a: assert property (
    store && !temp_fmt |-> fmt_word[14] == res_code[13] && fmt_word[13:0] == res_code)
    else $error("voltage word does not carry sign and code");
  ptr_wrap_a: assert property (
    clk_en && tx_load && ptr == 4'hf |=> ptr == 4'h0)
    else $error("pointer did not wrap to status");
  fresh_show_a: assert property (
    clk_en && tx_load && is_result && !ptr[0] |=> sda_oe_n == $past(fresh[rd_slot]))
    else $error("fresh flag not shown in upper byte");
  read_pause_a: assert property (
    clk_en && scl_fall && !start && !stop && bitcnt == 4'h8
      && state == mrf_pkg::st_addr && addr_hit && shreg[0] |=> !res_ready)
    else $error("read did not pause result updates");
  nack_quit_a: assert property (
    clk_en && scl_rise && !start && !stop && bitcnt == 4'h8
      && state == mrf_pkg::st_rdata && filt[0] |=> state == mrf_pkg::st_skip && sda_oe_n)
    else $error("slave kept sending after master refusal");
  addr_ignore_a: assert property (
    clk_en && scl_fall && !start && !stop && bitcnt == 4'h8
      && state == mrf_pkg::st_addr && !addr_hit |=> state == mrf_pkg::st_skip && sda_oe_n)
    else $error("foreign address acknowledged");
  wdata_ack_a: assert property (
    clk_en && scl_fall && !start && !stop && bitcnt == 4'h8
      && state == mrf_pkg::st_wdata |=> !sda_oe_n && ptr == $past(ptr_inc))
    else $error("data byte not acknowledged");

  read_seen_c: cover property (clk_en && tx_load && is_result);
  ctrl_write_c: cover property (clk_en && reg_we && ptr == mrf_pkg::ADDR_CONTROL);
  temp_store_c: cover property (store && temp_fmt);
  rep_start_c: cover property (clk_en && start && busy);
  nack_end_c: cover property (clk_en && state == mrf_pkg::st_skip && stop);
endmodule
`default_nettype wire
